// ---- design/adcsp_defs.svh ----
`ifndef ADCSP_DEFS_SVH
`define ADCSP_DEFS_SVH

// System clock period and link timing, in ns
`define ADCSP_SYS_NS 10
`define ADCSP_SCLK_NS 160
`define ADCSP_ACLK_NS 640

// Derived cycle counts (half periods round down, waits round up via margin)
`define ADCSP_SCLK_HALF ((`ADCSP_SCLK_NS / 2) / `ADCSP_SYS_NS)
`define ADCSP_ACLK_HALF ((`ADCSP_ACLK_NS / 2) / `ADCSP_SYS_NS)
`define ADCSP_CS_SETUP ((3 * `ADCSP_ACLK_NS + `ADCSP_SYS_NS - 1) / `ADCSP_SYS_NS)
`define ADCSP_CONV_WAIT (((`ADCSP_CONV_ACLKS + 4) * `ADCSP_ACLK_NS) / `ADCSP_SYS_NS)

// Deglitch and conversion lengths in conversion-clock falling edges
`define ADCSP_DEGLITCH_FALLS 2'h2
`define ADCSP_CONV_ACLKS 12

// Word sizes
`define ADCSP_CFG_BITS 5'h08
`define ADCSP_RES_BITS 10
`define ADCSP_FRAME_BITS 16

// Configuration word fields (bit 7 is received first)
`define ADCSP_CFG_MUX_HI 7
`define ADCSP_CFG_MUX_LO 4
`define ADCSP_CFG_POL 3
`define ADCSP_CFG_ORDER 2
`define ADCSP_CFG_LEN_HI 1
`define ADCSP_CFG_LEN_LO 0

// Word lengths in bits
`define ADCSP_LEN_08 5'h08
`define ADCSP_LEN_10 5'h0A
`define ADCSP_LEN_12 5'h0C
`define ADCSP_LEN_16 5'h10

// Result clamps and reset values
`define ADCSP_UNI_MAX 10'h3FF
`define ADCSP_BIP_MAX 10'h1FF
`define ADCSP_BIP_MIN 10'h200
`define ADCSP_ORDER_RST 1'h1

`endif

// ---- design/adcsp_pkg.sv ----
`include "adcsp_defs.svh"

package adcsp_pkg;

	// Device transfer states
	typedef enum logic [1:0] {
		ADCSP_D_IDLE = 2'h0,
		ADCSP_D_SHIFT = 2'h1,
		ADCSP_D_HOLD = 2'h3
	} adcsp_dev_st_t;

	// Host transfer states
	typedef enum logic [1:0] {
		ADCSP_H_IDLE = 2'h0,
		ADCSP_H_SETUP = 2'h1,
		ADCSP_H_SHIFT = 2'h3,
		ADCSP_H_GAP = 2'h2
	} adcsp_hst_st_t;

	// Length select code to word length in bits
	function automatic logic [4:0] adcsp_len_bits(input logic [1:0] sel);
		logic [4:0] n;
		unique case (sel)
			2'h0: n = `ADCSP_LEN_08;
			2'h1: n = `ADCSP_LEN_10;
			2'h2: n = `ADCSP_LEN_12;
			2'h3: n = `ADCSP_LEN_16;
		endcase
		return n;
	endfunction

endpackage

// ---- design/adcsp_if.sv ----
`timescale 1ns/1ns
// Four-wire serial link plus conversion clock
interface adcsp_if;
	logic cs_n;
	logic sclk;
	logic din;
	logic aclk;
	logic dout;
	logic dout_oe;

	modport dev (input cs_n, input sclk, input din, input aclk, output dout, output dout_oe);
	modport host (output cs_n, output sclk, output din, output aclk, input dout);
endinterface

// ---- design/adcsp_deglitch.sv ----
`timescale 1ns/1ns
`include "adcsp_defs.svh"
// Chip-select deglitcher timed by conversion-clock falling edges
module adcsp_deglitch (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// Synchronised chip select and conversion clock edge
	input wire logic i_cs_n,
	input wire logic i_aclk_fall,
	// Recognised select level
	output logic o_cs_low
);
	import adcsp_pkg::*;

	logic low_r, low_nxt;
	logic [1:0] cnt_r, cnt_nxt;

	// A change must survive two falling edges; any return to the accepted level restarts the count
	always_comb begin
		low_nxt = low_r;
		cnt_nxt = cnt_r;
		if (~i_cs_n == low_r) begin
			cnt_nxt = 2'h0;
		end else if (i_aclk_fall) begin
			if (cnt_r + 2'h1 == `ADCSP_DEGLITCH_FALLS) begin
				low_nxt = ~i_cs_n;
				cnt_nxt = 2'h0;
			end else begin
				cnt_nxt = cnt_r + 2'h1;
			end
		end
	end

	// Starts deselected
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			low_r <= 1'h0;
			cnt_r <= 2'h0;
		end else begin
			low_r <= low_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	assign o_cs_low = low_r;
endmodule

// ---- design/adcsp_device.sv ----
// Contract
// - Bipolar results are ten-bit two's complement.
// - Order bit one gives MSB first, zero LSB.
// - Order choice applies to the following result word.
// - Configuration word always arrives in fixed order.
// - Length codes give 8, 10, 12, 16 bits.
// - Length bits size the word of same transfer.
// - Host always sends valid length bits.
// - Host sends exactly word-length shift clocks.
// - Select pulses under one conversion clock ignored.
// - New select level needs two conversion falls.
// - Recognised select enables the result output.
// - Shift clock ignored while deselected.
// - Host holds shift clock low during conversion.
// - Select held low: first bit after conversion.
// - Sixteen-bit words end with six zeros.
// - Launch on falling edge, sample on rising.
// - Config taken on first eight rising edges.
// - Polarity bit one unipolar, zero bipolar.
// - Result leaves next cycle; conversion starts afterwards.
`timescale 1ns/1ns
`include "adcsp_defs.svh"
module adcsp_device (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// Serial link
	adcsp_if.dev link,
	// Converter core side
	input wire logic signed [10:0] i_vin,
	output logic o_conv_start,
	output logic o_busy,
	output logic [3:0] o_mux_sel,
	output logic o_unipolar,
	output logic [9:0] o_result,
	output logic o_selected
);
	import adcsp_pkg::*;

	// Pin order in the synchroniser vectors: cs_n, sclk, din, aclk
	logic [3:0] pin_s1_r, pin_s2_r, pin_d_r;
	logic sclk_rise, sclk_fall, aclk_fall, din_s, cs_low;

	adcsp_dev_st_t st_r, st_nxt;
	logic [7:0] cfg_r, cfg_nxt, cfg_now;
	logic [4:0] cnt_r, cnt_nxt, cnt_inc;
	logic [15:0] sr_r, sr_nxt, sr_sh;
	logic ord_r, ord_nxt, next_ord_r, next_ord_nxt;
	logic dout_r, dout_nxt, oe_r, oe_nxt;
	logic busy_r, busy_nxt, start_r, start_nxt;
	logic [3:0] conv_r, conv_nxt, mux_r, mux_nxt;
	logic pol_r, pol_nxt;
	logic [9:0] res_r, res_nxt, code;

	// Two flops on every pin, a third only for edge detection
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			pin_s1_r <= 4'h8;
			pin_s2_r <= 4'h8;
			pin_d_r <= 4'h8;
		end else begin
			pin_s1_r <= {link.cs_n, link.sclk, link.din, link.aclk};
			pin_s2_r <= pin_s1_r;
			pin_d_r <= pin_s2_r;
		end
	end

	// Edge pulses on the system clock
	assign sclk_rise = pin_s2_r[2] & ~pin_d_r[2];
	assign sclk_fall = ~pin_s2_r[2] & pin_d_r[2];
	assign din_s = pin_s2_r[1];
	assign aclk_fall = ~pin_s2_r[0] & pin_d_r[0];

	adcsp_deglitch u_deglitch (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_cs_n(pin_s2_r[3]),
		.i_aclk_fall(aclk_fall),
		.o_cs_low(cs_low)
	);

	// Result coding from the sampled input; out-of-span values clamp to the end codes
	always_comb begin
		if (pol_r) begin
			code = i_vin[10] ? 10'h000 : i_vin[9:0];
		end else if (i_vin > $signed({1'h0, `ADCSP_BIP_MAX})) begin
			code = `ADCSP_BIP_MAX;
		end else if (i_vin < $signed({1'h1, `ADCSP_BIP_MIN})) begin
			code = `ADCSP_BIP_MIN;
		end else begin
			code = i_vin[9:0];
		end
	end

	// Config bits so far including the one arriving now; fixed order regardless of output order
	assign cfg_now = (cnt_r < `ADCSP_CFG_BITS) ? {cfg_r[6:0], din_s} : cfg_r;
	assign cnt_inc = cnt_r + 5'h01;
	// Next output frame bit: left for MSB first, right for LSB first, zeros fill behind
	assign sr_sh = ord_r ? {sr_r[14:0], 1'h0} : {1'h0, sr_r[15:1]};

	// Transfer, configuration and conversion next state
	always_comb begin
		st_nxt = st_r;
		cfg_nxt = cfg_r;
		cnt_nxt = cnt_r;
		sr_nxt = sr_r;
		ord_nxt = ord_r;
		next_ord_nxt = next_ord_r;
		dout_nxt = dout_r;
		oe_nxt = oe_r;
		busy_nxt = busy_r;
		start_nxt = 1'h0;
		conv_nxt = conv_r;
		mux_nxt = mux_r;
		pol_nxt = pol_r;
		res_nxt = res_r;
		// Conversion runs on conversion-clock falls whatever the link does
		if (busy_r && aclk_fall) begin
			if (conv_r == 4'(`ADCSP_CONV_ACLKS - 1)) begin
				busy_nxt = 1'h0;
				res_nxt = code;
			end else begin
				conv_nxt = conv_r + 4'h1;
			end
		end
		unique case (st_r)
			ADCSP_D_IDLE: begin
				// Shift clock is not even looked at here
				cfg_nxt = 8'h00;
				cnt_nxt = 5'h00;
				if (cs_low) begin
					oe_nxt = 1'h1;
					st_nxt = ADCSP_D_HOLD;
					if (!busy_r) begin
						st_nxt = ADCSP_D_SHIFT;
						ord_nxt = next_ord_r;
						sr_nxt = next_ord_r ? {res_r, 6'h00} : {6'h00, res_r};
						dout_nxt = next_ord_r ? res_r[9] : res_r[0];
					end
				end
			end
			ADCSP_D_SHIFT: begin
				if (!cs_low) begin
					oe_nxt = 1'h0;
					st_nxt = ADCSP_D_IDLE;
				end else if (sclk_rise) begin
					cfg_nxt = cfg_now;
					cnt_nxt = cnt_inc;
					// Word ends at the selected length, known once all eight bits are in
					if (cnt_inc >= `ADCSP_CFG_BITS &&
						cnt_inc == adcsp_len_bits(cfg_now[`ADCSP_CFG_LEN_HI:`ADCSP_CFG_LEN_LO])) begin
						st_nxt = ADCSP_D_HOLD;
						next_ord_nxt = cfg_now[`ADCSP_CFG_ORDER];
						pol_nxt = cfg_now[`ADCSP_CFG_POL];
						mux_nxt = cfg_now[`ADCSP_CFG_MUX_HI:`ADCSP_CFG_MUX_LO];
						busy_nxt = 1'h1;
						conv_nxt = 4'h0;
						start_nxt = 1'h1;
					end
				end else if (sclk_fall && cnt_r != 5'h00) begin
					sr_nxt = sr_sh;
					dout_nxt = ord_r ? sr_sh[15] : sr_sh[0];
				end
			end
			ADCSP_D_HOLD: begin
				// Output stands still; with select kept low the next word starts at conversion end
				if (!cs_low) begin
					oe_nxt = 1'h0;
					st_nxt = ADCSP_D_IDLE;
				end else if (!busy_r) begin
					st_nxt = ADCSP_D_SHIFT;
					cfg_nxt = 8'h00;
					cnt_nxt = 5'h00;
					ord_nxt = next_ord_r;
					sr_nxt = next_ord_r ? {res_r, 6'h00} : {6'h00, res_r};
					dout_nxt = next_ord_r ? res_r[9] : res_r[0];
				end
			end
			default: begin
				st_nxt = ADCSP_D_IDLE;
				oe_nxt = 1'h0;
			end
		endcase
	end

	// State registers
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			st_r <= ADCSP_D_IDLE;
			cfg_r <= 8'h00;
			cnt_r <= 5'h00;
			sr_r <= 16'h0000;
			ord_r <= `ADCSP_ORDER_RST;
			next_ord_r <= `ADCSP_ORDER_RST;
			dout_r <= 1'h0;
			oe_r <= 1'h0;
			busy_r <= 1'h0;
			start_r <= 1'h0;
			conv_r <= 4'h0;
			mux_r <= 4'h0;
			pol_r <= 1'h0;
			res_r <= 10'h000;
		end else begin
			st_r <= st_nxt;
			cfg_r <= cfg_nxt;
			cnt_r <= cnt_nxt;
			sr_r <= sr_nxt;
			ord_r <= ord_nxt;
			next_ord_r <= next_ord_nxt;
			dout_r <= dout_nxt;
			oe_r <= oe_nxt;
			busy_r <= busy_nxt;
			start_r <= start_nxt;
			conv_r <= conv_nxt;
			mux_r <= mux_nxt;
			pol_r <= pol_nxt;
			res_r <= res_nxt;
		end
	end

	// Outputs
	assign link.dout = dout_r;
	assign link.dout_oe = oe_r;
	assign o_conv_start = start_r;
	assign o_busy = busy_r;
	assign o_mux_sel = mux_r;
	assign o_unipolar = pol_r;
	assign o_result = res_r;
	assign o_selected = cs_low;
endmodule

// ---- design/adcsp_host.sv ----
`timescale 1ns/1ns
`include "adcsp_defs.svh"
// Host end: makes both link clocks, sends one configuration word, collects one result word
module adcsp_host (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// Serial link
	adcsp_if.host link,
	// User request
	input wire logic i_start,
	input wire logic [7:0] i_cfg,
	output logic o_ready,
	// User answer
	output logic o_done,
	output logic [15:0] o_rx
);
	import adcsp_pkg::*;

	adcsp_hst_st_t st_r, st_nxt;
	logic [5:0] acnt_r, acnt_nxt, hcnt_r, hcnt_nxt;
	logic aclk_r, aclk_nxt, cs_n_r, cs_n_nxt, sclk_r, sclk_nxt, din_r, din_nxt;
	logic [6:0] tx_r, tx_nxt;
	logic [15:0] rx_r, rx_nxt, out_r, out_nxt;
	logic [4:0] nbit_r, nbit_nxt, len_r, len_nxt;
	logic [11:0] wcnt_r, wcnt_nxt;
	logic done_r, done_nxt;
	logic [1:0] dout_s_r;

	// Result pin comes from the other end, so two flops first
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			dout_s_r <= 2'h0;
		end else begin
			dout_s_r <= {dout_s_r[0], link.dout};
		end
	end

	// Sequencer next state; conversion clock divider runs free
	always_comb begin
		st_nxt = st_r;
		acnt_nxt = acnt_r + 6'h01;
		aclk_nxt = aclk_r;
		cs_n_nxt = cs_n_r;
		sclk_nxt = sclk_r;
		din_nxt = din_r;
		tx_nxt = tx_r;
		rx_nxt = rx_r;
		out_nxt = out_r;
		nbit_nxt = nbit_r;
		len_nxt = len_r;
		wcnt_nxt = wcnt_r + 12'h001;
		hcnt_nxt = hcnt_r;
		done_nxt = 1'h0;
		if (acnt_r == 6'(`ADCSP_ACLK_HALF - 1)) begin
			acnt_nxt = 6'h00;
			aclk_nxt = ~aclk_r;
		end
		unique case (st_r)
			ADCSP_H_IDLE: begin
				sclk_nxt = 1'h0;
				if (i_start) begin
					st_nxt = ADCSP_H_SETUP;
					cs_n_nxt = 1'h0;
					din_nxt = i_cfg[7];
					tx_nxt = i_cfg[6:0];
					len_nxt = adcsp_len_bits(i_cfg[1:0]);
					nbit_nxt = 5'h00;
					rx_nxt = 16'h0000;
					wcnt_nxt = 12'h000;
				end
			end
			ADCSP_H_SETUP: begin
				// Wait past the select deglitch before the first edge
				if (wcnt_r == 12'(`ADCSP_CS_SETUP)) begin
					st_nxt = ADCSP_H_SHIFT;
					hcnt_nxt = 6'h00;
				end
			end
			ADCSP_H_SHIFT: begin
				hcnt_nxt = hcnt_r + 6'h01;
				if (hcnt_r == 6'(`ADCSP_SCLK_HALF - 1)) begin
					hcnt_nxt = 6'h00;
					sclk_nxt = ~sclk_r;
					if (!sclk_r) begin
						rx_nxt = {rx_r[14:0], dout_s_r[1]};
						nbit_nxt = nbit_r + 5'h01;
					end else if (nbit_r == len_r) begin
						st_nxt = ADCSP_H_GAP;
						cs_n_nxt = 1'h1;
						out_nxt = rx_r;
						done_nxt = 1'h1;
						wcnt_nxt = 12'h000;
					end else begin
						din_nxt = tx_r[6];
						tx_nxt = {tx_r[5:0], 1'h0};
					end
				end
			end
			ADCSP_H_GAP: begin
				// Covers deselect recognition and the whole conversion
				if (wcnt_r == 12'(`ADCSP_CONV_WAIT)) begin
					st_nxt = ADCSP_H_IDLE;
				end
			end
		endcase
	end

	// State registers
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			st_r <= ADCSP_H_IDLE;
			acnt_r <= 6'h00;
			aclk_r <= 1'h0;
			cs_n_r <= 1'h1;
			sclk_r <= 1'h0;
			din_r <= 1'h0;
			tx_r <= 7'h00;
			rx_r <= 16'h0000;
			out_r <= 16'h0000;
			nbit_r <= 5'h00;
			len_r <= `ADCSP_LEN_08;
			wcnt_r <= 12'h000;
			hcnt_r <= 6'h00;
			done_r <= 1'h0;
		end else begin
			st_r <= st_nxt;
			acnt_r <= acnt_nxt;
			aclk_r <= aclk_nxt;
			cs_n_r <= cs_n_nxt;
			sclk_r <= sclk_nxt;
			din_r <= din_nxt;
			tx_r <= tx_nxt;
			rx_r <= rx_nxt;
			out_r <= out_nxt;
			nbit_r <= nbit_nxt;
			len_r <= len_nxt;
			wcnt_r <= wcnt_nxt;
			hcnt_r <= hcnt_nxt;
			done_r <= done_nxt;
		end
	end

	// Outputs
	assign link.cs_n = cs_n_r;
	assign link.sclk = sclk_r;
	assign link.din = din_r;
	assign link.aclk = aclk_r;
	assign o_ready = (st_r == ADCSP_H_IDLE);
	assign o_done = done_r;
	assign o_rx = out_r;
endmodule

// ---- sim/adcsp_link_asserts.sv ----
`timescale 1ns/1ns
// Watches the link wires shared by both ends
module adcsp_link_asserts (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// Link wires
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic din,
	input wire logic aclk,
	input wire logic dout,
	input wire logic dout_oe
);
	logic [7:0] lo_r, lo_nxt, hi_r, hi_nxt, cf_r, cf_nxt;
	logic [3:0] sf_r, sf_nxt;
	logic [4:0] nr_r, nr_nxt, len;
	logic sc_r, sc_nxt, rise;
	assign rise = !sc_r && sclk;
	// Word length from the captured length bits
	assign len = (cf_r[1:0] == 2'h3) ? 5'h10 : 5'h08 + {2'h0, cf_r[1:0], 1'h0};
	// Select ages, cycles since shift fall, rises and config per frame
	always_comb begin
		lo_nxt = cs_n ? 8'h00 : lo_r + {7'h00, lo_r != 8'hFF};
		hi_nxt = !cs_n ? 8'h00 : hi_r + {7'h00, hi_r != 8'hFF};
		sf_nxt = (sc_r && !sclk) ? 4'h0 : sf_r + {3'h0, sf_r != 4'hF};
		nr_nxt = cs_n ? 5'h00 : nr_r + {4'h0, rise && nr_r != 5'h1F};
		cf_nxt = (rise && !cs_n && nr_r < 5'h08) ? {cf_r[6:0], din} : cf_r;
		sc_nxt = sclk;
		if (i_rst) begin
			{lo_nxt, hi_nxt, sf_nxt, nr_nxt, cf_nxt, sc_nxt} = '0;
		end
	end
	// Registers only; reset handled above
	always_ff @(posedge i_sys_clk) begin
		{lo_r, hi_r, sf_r, nr_r, cf_r, sc_r} <= {lo_nxt, hi_nxt, sf_nxt, nr_nxt, cf_nxt, sc_nxt};
	end
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	// Frame closes when select goes high
	sequence s_cs_rel;
		$rose(cs_n);
	endsequence
	// Two conversion falls need over one aclk period (64 cycles)
	sel_min_on_a: assert property ($rose(dout_oe) |-> lo_r >= 8'h3C)
		else $error("output enabled too early");
	sel_max_on_a: assert property (!cs_n && lo_r == 8'h96 |-> dout_oe)
		else $error("output not enabled");
	sel_min_off_a: assert property ($fell(dout_oe) |-> hi_r >= 8'h3C)
		else $error("output released too early");
	sel_max_off_a: assert property (cs_n && hi_r == 8'h96 |-> !dout_oe)
		else $error("output not released");
	dout_launch_a: assert property (dout_oe && $past(dout_oe) && $changed(dout) |-> sf_r inside {[4'h1:4'h6]})
		else $error("data bit not launched by shift fall");
	sclk_idle_a: assert property (cs_n |-> !sclk)
		else $error("shift clock outside frame");
	clk_count_a: assert property (s_cs_rel |-> nr_r == len)
		else $error("shift clocks differ from word length");
	word_hold_a: assert property (!cs_n && nr_r == len |=> cs_n || $stable(dout))
		else $error("output moved after word end");
	zero_fill_a: assert property (!cs_n && dout_oe && len == 5'h10 && nr_r >= 5'h0B |-> !dout)
		else $error("fill bit not zero");
endmodule

// ---- sim/test_adc_serial_config_port.sv ----
`timescale 1ns/1ns
// Host and device joined by the link; rows of config word and input
module test_adc_serial_config_port;
	logic i_sys_clk = 1'h0;
	logic i_rst = 1'h1;
	logic start = 1'h0;
	logic [7:0] cfg = 8'h00;
	logic signed [10:0] vin = 11'sh000;
	logic ready, done, conv, busy, polarity_sel, sel;
	logic [15:0] rx;
	logic [9:0] res;
	logic [3:0] mux;
	logic [9:0] pc = 10'h000;
	logic po = 1'h1;
	int n_fail = 0;
	int checks_done = 0;
	int n_conv = 0;
	// Config word, input, expected code; every length, order and polarity, clamps at both rails
	logic [28:0] rows [0:8] = '{{8'h5D, 11'h155, 10'h155}, {8'h28, 11'h2A5, 10'h2A5}, {8'h33, 11'h3FF, 10'h1FF},
		{8'h96, 11'h7FE, 10'h3FE}, {8'hCF, 11'h400, 10'h000}, {8'h41, 11'h4F0, 10'h200},
		{8'hE4, 11'h001, 10'h001}, {8'h1F, 11'h3FF, 10'h3FF}, {8'h09, 11'h000, 10'h000}};
	adcsp_if link ();
	adcsp_device adcsp_device_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .link(link), .i_vin(vin),
		.o_conv_start(conv), .o_busy(busy), .o_mux_sel(mux), .o_unipolar(polarity_sel), .o_result(res), .o_selected(sel));
	adcsp_host adcsp_host_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .link(link), .i_start(start),
		.i_cfg(cfg), .o_ready(ready), .o_done(done), .o_rx(rx));
	adcsp_link_asserts adcsp_link_asserts_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .cs_n(link.cs_n),
		.sclk(link.sclk), .din(link.din), .aclk(link.aclk), .dout(link.dout), .dout_oe(link.dout_oe));
	// 100 MHz clock
	always #5 i_sys_clk = ~i_sys_clk;
	// Conversion start pulses; one per accepted transfer, refused starts add none
	always @(posedge i_sys_clk) begin
		if (conv === 1'h1) begin
			n_conv <= n_conv + 1;
		end
	end
	// Received word: 16-bit frame in chosen order, cut to length
	function automatic logic [15:0] frame(input logic [9:0] r, input logic o, input logic [1:0] wl);
		logic [15:0] f;
		f = 16'h0000;
		for (int k = 0; k < 10; k++) f[15 - k] = o ? r[9 - k] : r[k];
		return f >> ((wl == 2'h3) ? 0 : 8 - 2 * wl);
	endfunction
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
		checks_done++;
		if (s !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// One transfer, then a start during the gap that must be refused
	task automatic run(input logic [7:0] c, input logic signed [10:0] v, input logic [9:0] e);
		int k;
		k = 0;
		while (ready !== 1'h1 && k < 3000) begin
			@(posedge i_sys_clk);
			k++;
		end
		// A wait that runs out shows up here as a mismatch
		chk("ready", 16'h0001, {15'h0000, ready});
		chk("oe", 16'h0000, {15'h0000, link.dout_oe});
		chk("idle", 16'h0000, {15'h0000, busy});
		start <= 1'h1;
		cfg <= c;
		vin <= v;
		@(posedge i_sys_clk);
		start <= 1'h0;
		k = 0;
		do begin
			@(posedge i_sys_clk);
			k++;
		end while (done !== 1'h1 && k < 3000);
		chk("done", 16'h0001, {15'h0000, done});
		chk("rx", frame(pc, po, c[1:0]), rx);
		chk("res", {6'h00, pc}, {6'h00, res});
		chk("mux", {12'h000, c[7:4]}, {12'h000, mux});
		chk("pol", {15'h0000, c[3]}, {15'h0000, polarity_sel});
		// Conversion already running, deselect not yet through the deglitcher
		chk("busy", 16'h0001, {15'h0000, busy});
		chk("sel", 16'h0001, {15'h0000, sel});
		pc = e;
		po = c[2];
		start <= 1'h1;
		cfg <= 8'hFF;
		@(posedge i_sys_clk);
		start <= 1'h0;
	endtask
	initial begin
		repeat (3) @(posedge i_sys_clk);
		i_rst <= 1'h0;
		@(posedge i_sys_clk);
		chk("oe", 16'h0000, {15'h0000, link.dout_oe});
		for (int i = 0; i < 9; i++) run(rows[i][28:21], rows[i][20:10], rows[i][9:0]);
		// Reset while a conversion runs: result and order go back to defaults
		i_rst <= 1'h1;
		repeat (3) @(posedge i_sys_clk);
		i_rst <= 1'h0;
		@(posedge i_sys_clk);
		chk("cs", 16'h0001, {15'h0000, link.cs_n});
		chk("rdy", 16'h0001, {15'h0000, ready});
		pc = 10'h000;
		po = 1'h1;
		run(8'h0D, 11'h155, 10'h155);
		run(8'h0F, 11'h000, 10'h000);
		// Eleven accepted transfers, eleven conversion starts
		chk("conv", 16'h000B, n_conv[15:0]);
		give_verdict();
	end
	// Watchdog: eleven transfers of under 2000 cycles each
	initial begin
		repeat (60000) @(posedge i_sys_clk);
		n_fail++;
		give_verdict();
	end
endmodule
